// ---- common/flash_ctl_defs.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef FLASH_CTL_DEFS_SVH
`define FLASH_CTL_DEFS_SVH
`define BANK_SEL_ADDR 8'h92
`define FLASH_CTL_ADDR 8'hd1
`define FLASH_STA_ADDR 8'hd3
`define FLASH_CTL_RESET 8'h00
`define KEY_FIRST 4'h5
`define KEY_LAUNCH 4'ha
`define KEY_MSB 7
`define KEY_LSB 4
`define LATCH_SPACE_BIT 3
`define OP_MSB 2
`define OP_LSB 0
`define OVR_MSB 7
`define OVR_LSB 5
`define PAGE_BYTES 128
`define PAGE_ADDR_W 7
`define PAGE_NUM_MSB 14
`define STA_ERR_BIT 2
`define STA_LOAD_BIT 1
`define STA_BUSY_BIT 0
`define PROG_TIME_US 20
`define CLK_MHZ 10
`define PROG_CYCLES (`PROG_TIME_US * `CLK_MHZ)
`endif

// ---- common/flash_ctl_pkg.sv ----
// Types shared by the flash access controller
package flash_ctl_pkg;
    typedef enum logic [1:0] {
        FETCH_USER,
        FETCH_BOOT,
        FETCH_EXT
    } fetch_src_t;
    typedef struct packed {
        logic we;
        logic re;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
    typedef struct packed {
        logic we;
        logic [15:0] addr;
        logic [7:0] wdata;
    } xdata_req_t;
    typedef enum logic [2:0] {
        OP_USER_ARRAY,
        OP_EXTRA_ROW,
        OP_ERASE_ALL,
        OP_LATCH_RESET,
        OP_SEC_BYTE,
        OP_FUSE_BYTE,
        OP_RSVD6,
        OP_RSVD7
    } flash_op_t;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PROG
    } prog_state_t;
    typedef struct packed {
        flash_op_t op;
        logic [2:0] bank;
        logic [7:0] page;
    } launch_t;
endpackage

// ---- src/page_latch_mem.sv ----
// One-page column latch buffer, registered read port for the array writer
module page_latch_mem #(
    parameter int DEPTH = 128,
    parameter int AW = 7
) (
    input wire logic core_clk_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [DEPTH];
    always_ff @(posedge core_clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule

// ---- src/flash_access_ctl.sv ----
// Flash program access controller: keyed launch, page latch, stall control
`include "flash_ctl_defs.svh"
//
// Summary of operation
// - Buffer holds exactly one 128-byte page
// - Buffer loads only from user or boot code
// - Boot-code programming never stalls the CPU
// - User-code programming stalls CPU, interrupts held
// - Stall ends on completion or resets
// - External code fetch denies load and launch
// - Reset aborts; only target page affected
// - Access only through the control registers
// - Bank select resets to zero, fetch bank strapped
// - Key 5 then A launches operation
// - Latch space bit steers external writes
// - Operation select picks area and operation
// - Control register resets to zero
// - Address low seven bits byte, upper page
// - Bad key sets error flag; cleared later
// - Busy flag read-only during programming
module flash_access_ctl #(
    parameter int PROG_CYCLES = `PROG_CYCLES
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input flash_ctl_pkg::reg_req_t reg_req_i,
    output logic [7:0] reg_rdata_o,
    input flash_ctl_pkg::xdata_req_t xdata_req_i,
    output logic xdata_ext_we_o,
    input flash_ctl_pkg::fetch_src_t fetch_src_i,
    input wire logic [2:0] boot_vector_setting_i,
    input wire logic irq_req_i,
    output logic irq_deliver_o,
    output logic cpu_halt_o,
    output flash_ctl_pkg::launch_t launch_o,
    output logic launch_valid_o,
    output logic array_we_o,
    output logic [6:0] array_addr_o,
    output logic [7:0] array_data_o,
    input wire logic flash_done_i
);
    import flash_ctl_pkg::*;
    typedef struct packed {
        logic [2:0] ovr;
        logic [2:0] fbank;
        logic [7:0] ctl;
        logic key5_armed;
        logic seq_err;
        logic loaded;
        logic busy;
        logic halt;
        logic irq_pend;
        logic [7:0] page;
        launch_t launch;
        logic launch_v;
        logic [15:0] cnt;
        prog_state_t st;
        logic [7:0] rdata;
        logic strap_done;
    } state_t;
    state_t s_reg, s_next;

    function automatic logic [2:0] strap_bank(input logic [2:0] brv);
        case (brv)
            3'h4: strap_bank = 3'h0;
            3'h5: strap_bank = 3'h1;
            3'h6: strap_bank = 3'h2;
            3'h3: strap_bank = 3'h4;
            default: strap_bank = 3'h0;
        endcase
    endfunction

    logic internal_fetch;
    logic latch_we;
    logic [7:0] mem_rdata;
    assign internal_fetch = (fetch_src_i != FETCH_EXT);

    ////////////////////////////////////////////////////////////////////
    // loads only internal
    assign latch_we = xdata_req_i.we && s_reg.ctl[`LATCH_SPACE_BIT]
                      && internal_fetch && !s_reg.busy;
    assign xdata_ext_we_o = xdata_req_i.we && !s_reg.ctl[`LATCH_SPACE_BIT];

    page_latch_mem #(
        .DEPTH(`PAGE_BYTES),
        .AW(`PAGE_ADDR_W)
    ) u_latch (
        .core_clk_i(core_clk_i),
        .we_i(latch_we),
        .waddr_i(xdata_req_i.addr[`PAGE_ADDR_W-1:0]),
        .wdata_i(xdata_req_i.wdata),
        .raddr_i(s_reg.cnt[`PAGE_ADDR_W-1:0]),
        .rdata_o(mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [3:0] key;
        key = reg_req_i.wdata[`KEY_MSB:`KEY_LSB];
        s_next = s_reg;
        s_next.launch_v = 1'b0;
        if (!s_reg.strap_done) begin
            s_next.strap_done = 1'b1;
            s_next.fbank = strap_bank(boot_vector_setting_i);
        end
        if (reg_req_i.we && reg_req_i.addr == `BANK_SEL_ADDR) begin
            s_next.ovr = reg_req_i.wdata[`OVR_MSB:`OVR_LSB];
            if (!s_reg.fbank[2]) begin
                s_next.fbank[1:0] = reg_req_i.wdata[1:0];
            end
        end
        if (reg_req_i.we && reg_req_i.addr == `FLASH_STA_ADDR
            && !reg_req_i.wdata[`STA_ERR_BIT]) begin
            s_next.seq_err = 1'b0;
        end
        if (reg_req_i.we && reg_req_i.addr == `FLASH_CTL_ADDR
            && !s_reg.busy) begin
            s_next.ctl = reg_req_i.wdata;
            s_next.key5_armed = (key == `KEY_FIRST);
            if (key == `KEY_LAUNCH) begin
                if (s_reg.key5_armed && internal_fetch) begin
                    s_next.seq_err = 1'b0;
                    s_next.launch_v = 1'b1;
                    s_next.launch.op = flash_op_t'(
                        reg_req_i.wdata[`OP_MSB:`OP_LSB]);
                    s_next.launch.bank = s_reg.ovr[2]
                        ? {1'b0, s_reg.ovr[1:0]} : s_reg.fbank;
                    s_next.launch.page = s_reg.page;
                    s_next.loaded = 1'b0;
                    s_next.busy = 1'b1;
                    s_next.cnt = '0;
                    s_next.st = ST_PROG;
                    s_next.halt = (fetch_src_i == FETCH_USER);
                end else begin
                    s_next.seq_err = 1'b1;
                end
            end
            else if (key != `KEY_FIRST && key != 4'h0) begin
                s_next.seq_err = 1'b1;
            end
        end
        // Placed after the launch so a same-cycle load keeps the flag set
        if (latch_we) begin
            s_next.loaded = 1'b1;
            s_next.page = xdata_req_i.addr[`PAGE_NUM_MSB:`PAGE_ADDR_W];
        end
        case (s_reg.st)
            ST_IDLE: begin
            end
            ST_PROG: begin
                if (s_reg.cnt != 16'(PROG_CYCLES)) begin
                    s_next.cnt = s_reg.cnt + 16'h0001;
                end
                if (flash_done_i) begin
                    s_next.busy = 1'b0;
                    s_next.halt = 1'b0;
                    s_next.st = ST_IDLE;
                end
            end
            default: s_next.st = ST_IDLE;
        endcase
        if (irq_req_i && s_reg.halt) begin
            s_next.irq_pend = 1'b1;
        end else if (!s_reg.halt) begin
            s_next.irq_pend = 1'b0;
        end
        case (reg_req_i.addr)
            `BANK_SEL_ADDR: s_next.rdata = {s_reg.ovr, 2'b00, s_reg.fbank};
            `FLASH_CTL_ADDR: s_next.rdata = s_reg.ctl;
            `FLASH_STA_ADDR: s_next.rdata = {5'h00, s_reg.seq_err,
                                             s_reg.loaded, s_reg.busy};
            default: s_next.rdata = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_reg <= '0;
            s_reg.ctl <= `FLASH_CTL_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign reg_rdata_o = s_reg.rdata;
    assign cpu_halt_o = s_reg.halt;
    assign irq_deliver_o = (irq_req_i || s_reg.irq_pend) && !s_reg.halt;
    assign launch_o = s_reg.launch;
    assign launch_valid_o = s_reg.launch_v;
    assign array_we_o = s_reg.busy;
    assign array_addr_o = s_reg.cnt[`PAGE_ADDR_W-1:0];
    assign array_data_o = mem_rdata;

    ////////////////////////////////////////////////////////////////////
    sequence s_key5;
        reg_req_i.we && reg_req_i.addr == `FLASH_CTL_ADDR && !s_reg.busy
        && reg_req_i.wdata[7:4] == 4'h5;
    endsequence
    sequence s_keya;
        reg_req_i.we && reg_req_i.addr == `FLASH_CTL_ADDR && !s_reg.busy
        && reg_req_i.wdata[7:4] == 4'ha && internal_fetch;
    endsequence
    property p_launch;
        @(posedge core_clk_i) disable iff (rst_i)
        s_key5 ##1 s_keya |=> launch_valid_o && s_reg.busy;
    endproperty
    a_launch: assert property (p_launch) else $error("no launch");
    property p_no_launch;
        @(posedge core_clk_i) disable iff (rst_i)
        launch_valid_o |-> $past(s_reg.key5_armed);
    endproperty
    a_no_launch: assert property (p_no_launch) else $error("bad launch");
    property p_ext_deny;
        @(posedge core_clk_i) disable iff (rst_i)
        fetch_src_i == FETCH_EXT |-> !latch_we;
    endproperty
    a_ext_deny: assert property (p_ext_deny) else $error("ext load");
    property p_boot_nostall;
        @(posedge core_clk_i) disable iff (rst_i)
        (s_keya and (fetch_src_i == FETCH_BOOT && s_reg.key5_armed))
        |=> !cpu_halt_o;
    endproperty
    a_boot_nostall: assert property (p_boot_nostall) else $error("stall");
    property p_user_stall;
        @(posedge core_clk_i) disable iff (rst_i)
        (s_keya and (fetch_src_i == FETCH_USER && s_reg.key5_armed))
        |=> cpu_halt_o;
    endproperty
    a_user_stall: assert property (p_user_stall) else $error("no stall");
    property p_done;
        @(posedge core_clk_i) disable iff (rst_i)
        s_reg.busy && flash_done_i |=> !cpu_halt_o && !s_reg.busy;
    endproperty
    a_done: assert property (p_done) else $error("stuck busy");
    property p_busy_hold;
        @(posedge core_clk_i) disable iff (rst_i)
        s_reg.busy && !flash_done_i |=> s_reg.busy;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy dropped");
    property p_irq_hold;
        @(posedge core_clk_i) disable iff (rst_i)
        cpu_halt_o |-> !irq_deliver_o;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq leak");
    property p_seq_err;
        @(posedge core_clk_i) disable iff (rst_i)
        (s_keya and !s_reg.key5_armed) |=> s_reg.seq_err;
    endproperty
    a_seq_err: assert property (p_seq_err) else $error("no error");
endmodule

// ---- sim/flash_done_model.sv ----
// Flash macro stand-in: ends each launched operation after a fixed delay
module flash_done_model #(
    parameter int DELAY = 12
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic launch_valid_i,
    output logic flash_done_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt_reg;
    logic done_reg;
    assign flash_done_o = done_reg;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_reg <= 8'h00;
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (launch_valid_i) begin
                cnt_reg <= DELAY[7:0];
            end else if (cnt_reg != 8'h00) begin
                cnt_reg <= cnt_reg - 8'h01;
                done_reg <= (cnt_reg == 8'h01);
            end
        end
    end
endmodule

// ---- sim/flash_access_ctl_test.sv ----
// Self-checking bench for the flash access controller
module flash_access_ctl_test;
    timeunit 1ns;
    timeprecision 1ns;
    import flash_ctl_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    reg_req_t req = '0;
    xdata_req_t xreq = '0;
    fetch_src_t fetch = FETCH_USER;
    logic irq = 1'b0;
    logic done, ext_we, irq_dlv, halt, lv, awe;
    logic [7:0] rdata, adata;
    logic [6:0] aaddr;
    launch_t lch;
    int n_mismatch = 0;
    int n_checks = 0;
    always #50 core_clk_i = ~core_clk_i;
    flash_access_ctl #(.PROG_CYCLES(8)) u_flash_access_ctl (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_req_i(req),
        .reg_rdata_o(rdata), .xdata_req_i(xreq), .xdata_ext_we_o(ext_we),
        .fetch_src_i(fetch), .boot_vector_setting_i(3'b101),
        .irq_req_i(irq), .irq_deliver_o(irq_dlv), .cpu_halt_o(halt),
        .launch_o(lch), .launch_valid_o(lv), .array_we_o(awe),
        .array_addr_o(aaddr), .array_data_o(adata), .flash_done_i(done)
    );
    flash_done_model u_flash_done_model (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .launch_valid_i(lv),
        .flash_done_o(done)
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic check8(input logic [7:0] got, exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h", $time, what, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(negedge core_clk_i) req = '{1'b1, 1'b0, a, d};
        @(negedge core_clk_i) req = '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk_i) req = '{1'b0, 1'b1, a, 8'h00};
        @(negedge core_clk_i) req = '0;
        d = rdata;
    endtask
    task automatic xwr(input logic [15:0] a, input logic exp);
        @(negedge core_clk_i) xreq = '{1'b1, a, 8'h3c};
        #1 check8({7'b0, ext_we}, {7'b0, exp}, "ext we");
        @(negedge core_clk_i) xreq = '0;
    endtask
    task automatic launch(input logic [2:0] op, input logic k5,
                          output logic seen, output launch_t got);
        seen = 1'b0;
        // Key 5 and key A go out on back-to-back edges
        if (k5) @(negedge core_clk_i) req = '{1'b1, 1'b0, 8'hd1,
                                               {4'h5, 1'b0, op}};
        wr(8'hd1, {4'ha, 1'b0, op});
        for (int k = 0; k < 4 && !seen; k++) begin
            if (lv === 1'b1) begin
                seen = 1'b1;
                got = lch;
            end else @(negedge core_clk_i);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        logic [7:0] d;
        rd(8'h92, d);
        check8(d, 8'h01, "bank sel");
        rd(8'hd1, d);
        check8(d, 8'h00, "flash_control");
        $display("test reset done");
    endtask
    task automatic t_user;
        logic [7:0] d;
        logic s;
        launch_t g;
        wr(8'hd1, 8'h08);
        xwr(16'h0185, 1'b0);
        rd(8'hd3, d);
        check8({7'b0, d[1]}, 8'h01, "loaded");
        wr(8'hd1, 8'h00);
        xwr(16'h0010, 1'b1);
        irq = 1'b1;
        launch(3'd0, 1'b1, s, g);
        check8({7'b0, s}, 8'h01, "launch");
        check8(g.page, 8'h03, "page");
        check8({5'b0, g.bank}, 8'h01, "bank");
        repeat (2) @(negedge core_clk_i);
        check8({6'b0, halt, irq_dlv}, 8'h02, "halt irq");
        check8({7'b0, awe}, 8'h01, "array we");
        check8({1'b0, aaddr}, 8'h02, "array addr");
        repeat (4) @(negedge core_clk_i);
        check8(adata, 8'h3c, "array data");
        rd(8'hd3, d);
        check8({7'b0, d[0]}, 8'h01, "busy");
        // Request gone before the stall ends, so only the held one shows
        irq = 1'b0;
        for (int k = 0; k < 40 && halt !== 1'b0; k++) @(negedge core_clk_i);
        check8({7'b0, halt}, 8'h00, "halt end");
        check8({7'b0, irq_dlv}, 8'h01, "irq replay");
        $display("test user done");
    endtask
    task automatic t_boot;
        logic s;
        launch_t g;
        fetch = FETCH_BOOT;
        wr(8'h92, 8'hc0);
        launch(3'd5, 1'b1, s, g);
        check8({5'b0, g.op}, 8'h05, "op");
        check8({5'b0, g.bank}, 8'h02, "forced bank");
        repeat (3) @(negedge core_clk_i);
        check8({7'b0, halt}, 8'h00, "no halt");
        repeat (20) @(negedge core_clk_i);
        $display("test boot done");
    endtask
    task automatic t_refuse;
        logic [7:0] d;
        logic s;
        launch_t g;
        fetch = FETCH_USER;
        launch(3'd0, 1'b0, s, g);
        check8({7'b0, s}, 8'h00, "lone A");
        rd(8'hd3, d);
        check8({7'b0, d[2]}, 8'h01, "seq err");
        wr(8'hd3, 8'h00);
        rd(8'hd3, d);
        check8({7'b0, d[2]}, 8'h00, "err clear");
        fetch = FETCH_EXT;
        wr(8'hd1, 8'h08);
        xwr(16'h0200, 1'b0);
        rd(8'hd3, d);
        check8({7'b0, d[1]}, 8'h00, "ext load");
        launch(3'd0, 1'b1, s, g);
        check8({7'b0, s}, 8'h00, "ext launch");
        $display("test refuse done");
    endtask
    task automatic t_abort;
        logic [7:0] d;
        logic s;
        launch_t g;
        fetch = FETCH_USER;
        launch(3'd0, 1'b1, s, g);
        repeat (2) @(negedge core_clk_i);
        rst_i = 1'b1;
        repeat (2) @(negedge core_clk_i);
        check8({7'b0, halt}, 8'h00, "reset halt");
        rst_i = 1'b0;
        repeat (2) @(negedge core_clk_i);
        rd(8'hd1, d);
        check8(d, 8'h00, "flash_control reset");
        $display("test abort done");
    endtask
    initial begin
        repeat (20) @(negedge core_clk_i);
        rst_i = 1'b0;
        repeat (2) @(negedge core_clk_i);
        t_reset();
        t_user();
        t_boot();
        t_refuse();
        t_abort();
        give_verdict();
    end
    initial begin
        repeat (3000) @(posedge core_clk_i);
        n_mismatch++;
        give_verdict();
    end
endmodule
